// *** bench/rtc_link_checker.sv ***
// Purpose: link framing checks between host end and device end
// Assumes: one clock domain, sclk half period of HALF clk cycles
// Notes:   sees only the interface wires
`timescale 1ns/10ps
module rtc_link_checker #(
  parameter int HALF = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  logic [8:0] low_cnt_r;
  logic [4:0] rise_cnt_r;
  logic       sclk_q_r;

  // counters kept in helper logic, repetition alone cannot span a frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_r  <= 9'h000;
      rise_cnt_r <= 5'h00;
      sclk_q_r   <= 1'b1;
    end else begin
      low_cnt_r  <= cs_n ? 9'h000 : low_cnt_r + 9'h001;
      rise_cnt_r <= cs_n ? 5'h00 : rise_cnt_r + {4'h0, sclk & ~sclk_q_r};
      sclk_q_r   <= sclk;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_sclk_idle_high: assert property (cs_n |-> sclk)
    else $error("sclk low outside a frame");
  a_frame_start_low: assert property ($fell(cs_n) |-> !sclk)
    else $error("frame did not open with sclk low");
  a_high_half_len: assert property ($rose(sclk) && !cs_n |-> sclk [*8])
    else $error("sclk high half too short");
  a_low_half_len: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("sclk low half too short");
  a_mosi_hold_high: assert property (!cs_n && sclk && $past(sclk) |-> $stable(mosi))
    else $error("mosi moved while sclk high");
  a_frame_bit_count: assert property ($rose(cs_n) |-> rise_cnt_r == 5'h10)
    else $error("frame did not carry sixteen bits");
  a_frame_low_span: assert property ($rose(cs_n) |-> int'(low_cnt_r) == 33 * HALF)
    else $error("frame select span wrong");
  a_frame_gap_min: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("gap between frames too short");
  c_frame_done: cover property ($rose(cs_n) && $past(miso));
endmodule

// *** bench/testbench.sv ***
// Purpose: end to end test of host end and clock device over the link
// Assumes: short tick period, ticks counted from reset release
// Notes:   checks are kept well away from tick edges
`timescale 1ns/10ps
module testbench;
  localparam int TICK = 20000;
  logic        clk;
  logic        rst_n;
  logic        main_pwr_ok;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        busy;
  logic        cal_mode;
  logic        dst_en;
  logic        flash_save;
  logic [15:0] flash_count;
  logic        ce;
  int          num_errors;
  int          check_count;
  int          cyc = 0;
  int          t0;
  int          save_seen = 0;

  rtc_spi_if u_rtc_spi_if ();
  rtc_host #(.SCLK_HALF(8)) u_rtc_host (.clk(clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .spi(u_rtc_spi_if.host), .busy(busy));
  rtc_dev #(.TICK_CYCLES(TICK)) u_rtc_dev (.clk(clk), .rst_n(rst_n), .ce(ce), .spi(u_rtc_spi_if.dev),
    .main_pwr_ok(main_pwr_ok), .cal_mode(cal_mode), .dst_en(dst_en), .flash_save(flash_save),
    .flash_count(flash_count));
  rtc_link_checker #(.HALF(8)) u_rtc_link_checker (.clk(clk), .rst_n(rst_n), .sclk(u_rtc_spi_if.sclk),
    .cs_n(u_rtc_spi_if.cs_n), .mosi(u_rtc_spi_if.mosi), .miso(u_rtc_spi_if.miso));

  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  // every cycle of the save pulse is counted, so a long pulse shows up
  always @(posedge clk) if (flash_save === 1'b1) save_seen <= save_seen + 1;

  task automatic close_out();
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    q = avs_readdata;
    if (n >= 100) num_errors++;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  // one frame, then poll status until the link is idle again
  task automatic frame(input logic [15:0] f);
    logic [31:0] q;
    int          n;
    av_xfer(1'b1, rtc_pkg::AV_TX, {16'h0000, f}, q);
    n = 0;
    do begin
      av_xfer(1'b0, rtc_pkg::AV_STAT, 32'h0000_0000, q);
      n++;
    end while (q[0] !== 1'b0 && n < 400);
    if (n >= 400) num_errors++;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    frame({1'b1, a, d});
  endtask

  // answer arrives on the frame after the request
  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    logic [31:0] q;
    frame({1'b0, a, 8'h00});
    frame({1'b0, a, 8'h00});
    av_xfer(1'b0, rtc_pkg::AV_RX, 32'h0000_0000, q);
    chk16(q[15:0], exp);
  endtask

  task automatic wait_tick(input int k);
    while (cyc < t0 + k * TICK + 1000) @(posedge clk);
  endtask

  initial begin
    #950_000;
    num_errors++;
    close_out();
  end

  initial begin
    logic [31:0] q;
    clk = 1'b0;
    rst_n = 1'b0;
    main_pwr_ok = 1'b1;
    ce = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    num_errors = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t0 = cyc;
    rd(rtc_pkg::A_SEC, 16'h0000);
    rd(rtc_pkg::A_HOUR, 16'h0000);
    rd(rtc_pkg::A_MON, 16'h0000);
    chk16({15'h0000, cal_mode}, 16'h0000);
    av_xfer(1'b0, 4'hC, 32'h0000_0000, q);
    chk16(q[15:0], 16'h0000);
    wr(rtc_pkg::A_PAGE, rtc_pkg::PG_CFG);
    wr(rtc_pkg::A_CFG, 8'h03);
    chk16({14'h0000, dst_en, cal_mode}, 16'h0003);
    wr(rtc_pkg::A_CMD, 8'h08);
    chk16(flash_count, 16'h0001);
    chk16(16'(save_seen), 16'h0001);
    chk16({15'h0000, busy}, 16'h0000);
    wr(rtc_pkg::A_PAGE, rtc_pkg::PG_FLASH);
    rd(rtc_pkg::A_FCNT, 16'h0001);
    wr(rtc_pkg::A_PAGE, rtc_pkg::PG_CFG);
    main_pwr_ok <= 1'b0;
    wr(rtc_pkg::A_CFG, 8'h00);
    rd(rtc_pkg::A_CFG, 16'h0000);
    main_pwr_ok <= 1'b1;
    rd(rtc_pkg::A_CFG, 16'h0003);
    wr(rtc_pkg::A_CFG, 8'h01);
    chk16({14'h0000, dst_en, cal_mode}, 16'h0001);
    wr(rtc_pkg::A_PAGE, rtc_pkg::PG_DATA);
    // unused bits set on purpose, they must be dropped
    wr(rtc_pkg::A_SEC, 8'hFA);
    wr(rtc_pkg::A_MIN, 8'hFB);
    wr(rtc_pkg::A_HOUR, 8'hD7);
    wr(rtc_pkg::A_DAY, 8'hFF);
    wr(rtc_pkg::A_MON, 8'hFC);
    rd(rtc_pkg::A_SEC, 16'h0000);
    wr(rtc_pkg::A_YEAR, 8'hE3);
    rd(rtc_pkg::A_MON, 16'h0000);
    wait_tick(1);
    rd(rtc_pkg::A_SEC, 16'h3B3A);
    rd(rtc_pkg::A_HOUR, 16'h1F17);
    rd(rtc_pkg::A_MON, 16'h630C);
    wait_tick(2);
    rd(rtc_pkg::A_SEC, 16'h3B3B);
    wait_tick(3);
    rd(rtc_pkg::A_SEC, 16'h0000);
    rd(rtc_pkg::A_HOUR, 16'h0100);
    rd(rtc_pkg::A_MON, 16'h0001);
    // enable low across more than a tick period must stop the count
    ce <= 1'b0;
    repeat (TICK + 500) @(posedge clk);
    ce <= 1'b1;
    rd(rtc_pkg::A_SEC, 16'h0000);
    close_out();
  end
endmodule

// *** inc/rtc_pkg.sv ***
// Purpose: shared constants for the real-time clock device and its host end
// Assumes: 100 MHz clk, 16-bit serial frames, paged byte addresses
// Notes:   time fields are binary, one byte lane each on the link
package rtc_pkg;
  // clock and timing
  localparam int CLK_HZ        = 100_000_000;
  localparam int TICK_S        = 1;
  localparam int TICK_CYC      = TICK_S * CLK_HZ;
  localparam int SCLK_HALF_CYC = 8;
  localparam int FRAME_BITS    = 16;
  // frame layout
  localparam int WR_BIT        = 15;
  localparam int ADDR_MSB      = 14;
  localparam int ADDR_LSB      = 8;
  localparam int DATA_MSB      = 7;
  // pages
  localparam logic [7:0] PG_DATA  = 8'h00;
  localparam logic [7:0] PG_FLASH = 8'h02;
  localparam logic [7:0] PG_CFG   = 8'h03;
  // byte addresses within a page
  localparam logic [6:0] A_PAGE = 7'h00;
  localparam logic [6:0] A_CMD  = 7'h02;
  localparam logic [6:0] A_CFG  = 7'h0A;
  localparam logic [6:0] A_SEC  = 7'h78;
  localparam logic [6:0] A_MIN  = 7'h79;
  localparam logic [6:0] A_HOUR = 7'h7A;
  localparam logic [6:0] A_DAY  = 7'h7B;
  localparam logic [6:0] A_MON  = 7'h7C;
  localparam logic [6:0] A_YEAR = 7'h7D;
  localparam logic [6:0] A_FCNT = 7'h7C;
  // field positions
  localparam int CFG_MODE_BIT  = 0;
  localparam int CFG_DST_BIT   = 1;
  localparam int CMD_SAVE_BIT  = 3;
  // field limits
  localparam logic [7:0] SEC_MAX   = 8'h3B;
  localparam logic [7:0] MIN_MAX   = 8'h3B;
  localparam logic [7:0] HOUR_MAX  = 8'h17;
  localparam logic [7:0] DAY_MAX   = 8'h1F;
  localparam logic [7:0] DAY_30    = 8'h1E;
  localparam logic [7:0] DAY_FEB   = 8'h1C;
  localparam logic [7:0] DAY_LEAP  = 8'h1D;
  localparam logic [7:0] MON_MAX   = 8'h0C;
  localparam logic [7:0] YEAR_MAX  = 8'h63;
  localparam logic [7:0] CAL_MIN   = 8'h01;
  localparam logic [7:0] TIME_RST  = 8'h00;
  // host register offsets (byte addresses)
  localparam logic [3:0] AV_TX   = 4'h0;
  localparam logic [3:0] AV_RX   = 4'h4;
  localparam logic [3:0] AV_STAT = 4'h8;
endpackage

// *** inc/rtc_spi_if.sv ***
`timescale 1ns/10ps
// Purpose: serial link between host end and clock device
// Assumes: host makes sclk from its own clock, idle high
// Notes:   plain wires, no clocking block
interface rtc_spi_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport dev (input sclk, input cs_n, input mosi, output miso);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

// *** rtl/rtc_dev.sv ***
// Purpose: real-time clock device end, paged registers over the serial link
// Assumes: link pins synchronised here, sclk half period of at least 6 clk
// Notes:   one tick counter; staged set lands only on a tick
// Operation
// - config bit selects stopwatch or calendar mode
// - stopwatch mode starts all fields at zero
// - host writes seconds first, year byte last
// - staged fields wait for year byte write
// - loaded values appear at next seconds tick
// - year write always last, activates staging
// - minutes bits 13:8, seconds bits 5:0
// - day bits 12:8, hours bits 5:0
// - year bits 14:8, month bits 3:0
// - second config bit for daylight saving
// - host selects calendar mode before loading time
// - command bit 3 saves settings to flash
// - timer runs unpowered; reads need main power
// - flash save counts one write cycle
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/10ps
module rtc_dev #(
  parameter int TICK_CYCLES = rtc_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // link
  rtc_spi_if.dev           spi,
  // supply status
  input  wire logic        main_pwr_ok,
  // user side
  output logic             cal_mode,
  output logic             dst_en,
  output logic             flash_save,
  output logic [15:0]      flash_count
);
  logic [2:0]  sclk_s;
  logic [2:0]  cs_s;
  logic [1:0]  mosi_s;
  logic [4:0]  bit_cnt_r;
  logic [15:0] rx_sh_r;
  logic [15:0] tx_sh_r;
  logic [15:0] resp_r;
  logic [7:0]  page_r;
  logic [31:0] tick_cnt_r;
  logic        tick;
  logic        load_pend_r;
  logic [7:0]  sec_r, min_r, hour_r, day_r, mon_r, year_r;
  logic [7:0]  st_sec_r, st_min_r, st_hour_r, st_day_r, st_mon_r, st_year_r;
  logic [7:0]  sec_nxt, min_nxt, hour_nxt, day_nxt, mon_nxt, year_nxt;
  logic [7:0]  day_lim, cal_lo;
  logic        frame_go;
  logic        wr;
  logic [6:0]  addr;
  logic [7:0]  dat;
  logic [15:0] rd_word;
  logic        sclk_rise, sclk_fall, cs_fall;

  function automatic logic [7:0] wrap_inc(input logic [7:0] v, input logic [7:0] hi, input logic [7:0] lo);
    return (v >= hi) ? lo : v + 8'h01;
  endfunction

  function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y);
    logic [7:0] n;
    n = rtc_pkg::DAY_MAX;
    if (m == 8'h02) begin
      n = (y[1:0] == 2'b00) ? rtc_pkg::DAY_LEAP : rtc_pkg::DAY_FEB;
    end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h0B) begin
      n = rtc_pkg::DAY_30;
    end
    return n;
  endfunction

  // link pins pass two flops before use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s <= 3'b111;
      cs_s   <= 3'b111;
      mosi_s <= 2'b00;
    end else if (ce) begin
      sclk_s <= {sclk_s[1:0], spi.sclk};
      cs_s   <= {cs_s[1:0], spi.cs_n};
      mosi_s <= {mosi_s[0], spi.mosi};
    end
  end

  assign sclk_rise = sclk_s[1] & ~sclk_s[2] & ~cs_s[1];
  assign sclk_fall = ~sclk_s[1] & sclk_s[2] & ~cs_s[1];
  assign cs_fall   = ~cs_s[1] & cs_s[2];
  assign frame_go  = cs_s[1] & ~cs_s[2] & (bit_cnt_r == 5'(rtc_pkg::FRAME_BITS));
  assign wr        = rx_sh_r[rtc_pkg::WR_BIT] & main_pwr_ok;
  assign addr      = rx_sh_r[rtc_pkg::ADDR_MSB:rtc_pkg::ADDR_LSB];
  assign dat       = rx_sh_r[rtc_pkg::DATA_MSB:0];

  // shift in on rise, out on fall after first bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_r <= 5'h00;
      rx_sh_r   <= 16'h0000;
      tx_sh_r   <= 16'h0000;
    end else if (ce) begin
      if (cs_fall) begin
        bit_cnt_r <= 5'h00;
        tx_sh_r   <= resp_r;
      end else if (sclk_rise) begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
        rx_sh_r   <= {rx_sh_r[14:0], mosi_s[1]};
      end else if (sclk_fall && bit_cnt_r != 5'h00) begin
        tx_sh_r   <= {tx_sh_r[14:0], 1'b0};
      end
    end
  end

  assign spi.miso = tx_sh_r[15];

  // read word for the even address; answer goes out next frame
  always_comb begin
    rd_word = 16'h0000;
    if (addr[6:1] == rtc_pkg::A_PAGE[6:1]) begin
      rd_word = {8'h00, page_r};
    end else if (page_r == rtc_pkg::PG_DATA) begin
      if (addr[6:1] == rtc_pkg::A_SEC[6:1]) begin
        rd_word = {2'b00, min_r[5:0], 2'b00, sec_r[5:0]};
      end else if (addr[6:1] == rtc_pkg::A_HOUR[6:1]) begin
        rd_word = {3'b000, day_r[4:0], 2'b00, hour_r[5:0]};
      end else if (addr[6:1] == rtc_pkg::A_MON[6:1]) begin
        rd_word = {1'b0, year_r[6:0], 4'h0, mon_r[3:0]};
      end
    end else if (page_r == rtc_pkg::PG_CFG && addr[6:1] == rtc_pkg::A_CFG[6:1]) begin
      rd_word = {14'h0000, dst_en, cal_mode};
    end else if (page_r == rtc_pkg::PG_FLASH && addr[6:1] == rtc_pkg::A_FCNT[6:1]) begin
      rd_word = flash_count;
    end
  end

  // no read service without main power
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_r <= 16'h0000;
    end else if (ce && frame_go) begin
      resp_r <= (main_pwr_ok && !rx_sh_r[rtc_pkg::WR_BIT]) ? rd_word : 16'h0000;
    end
  end

  // page, config, command
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      page_r      <= rtc_pkg::PG_DATA;
      cal_mode    <= 1'b0;
      dst_en      <= 1'b0;
      flash_save  <= 1'b0;
      flash_count <= 16'h0000;
    end else if (ce) begin
      flash_save <= 1'b0;
      if (frame_go && wr) begin
        if (addr == rtc_pkg::A_PAGE) begin
          page_r <= dat;
        end else if (page_r == rtc_pkg::PG_CFG && addr == rtc_pkg::A_CFG) begin
          cal_mode <= dat[rtc_pkg::CFG_MODE_BIT];
          dst_en   <= dat[rtc_pkg::CFG_DST_BIT];
        end else if (page_r == rtc_pkg::PG_CFG && addr == rtc_pkg::A_CMD && dat[rtc_pkg::CMD_SAVE_BIT]) begin
          flash_save  <= 1'b1;
          flash_count <= flash_count + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_sec_r  <= rtc_pkg::TIME_RST;
      st_min_r  <= rtc_pkg::TIME_RST;
      st_hour_r <= rtc_pkg::TIME_RST;
      st_day_r  <= rtc_pkg::TIME_RST;
      st_mon_r  <= rtc_pkg::TIME_RST;
      st_year_r <= rtc_pkg::TIME_RST;
    end else if (ce && frame_go && wr && page_r == rtc_pkg::PG_DATA) begin
      if (addr == rtc_pkg::A_SEC)  st_sec_r  <= {2'b00, dat[5:0]};
      if (addr == rtc_pkg::A_MIN)  st_min_r  <= {2'b00, dat[5:0]};
      if (addr == rtc_pkg::A_HOUR) st_hour_r <= {2'b00, dat[5:0]};
      if (addr == rtc_pkg::A_DAY)  st_day_r  <= {3'b000, dat[4:0]};
      if (addr == rtc_pkg::A_MON)  st_mon_r  <= {4'h0, dat[3:0]};
      if (addr == rtc_pkg::A_YEAR) st_year_r <= {1'b0, dat[6:0]};
    end
  end

  // year write arms the load; set beats the tick clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_pend_r <= 1'b0;
    end else if (ce) begin
      if (frame_go && wr && page_r == rtc_pkg::PG_DATA && addr == rtc_pkg::A_YEAR) begin
        load_pend_r <= 1'b1;
      end else if (tick) begin
        load_pend_r <= 1'b0;
      end
    end
  end

  // seconds tick, runs whenever ce is high so unpowered main logic never stops it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= 32'h0000_0000;
    end else if (ce) begin
      tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
    end
  end

  assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

  // carry chain, calendar uses month lengths
  always_comb begin
    day_lim  = cal_mode ? month_len(mon_r, year_r) : rtc_pkg::DAY_MAX;
    cal_lo   = cal_mode ? rtc_pkg::CAL_MIN : rtc_pkg::TIME_RST;
    sec_nxt  = wrap_inc(sec_r, rtc_pkg::SEC_MAX, rtc_pkg::TIME_RST);
    min_nxt  = min_r;
    hour_nxt = hour_r;
    day_nxt  = day_r;
    mon_nxt  = mon_r;
    year_nxt = year_r;
    if (sec_r >= rtc_pkg::SEC_MAX) begin
      min_nxt = wrap_inc(min_r, rtc_pkg::MIN_MAX, rtc_pkg::TIME_RST);
      if (min_r >= rtc_pkg::MIN_MAX) begin
        hour_nxt = wrap_inc(hour_r, rtc_pkg::HOUR_MAX, rtc_pkg::TIME_RST);
        if (hour_r >= rtc_pkg::HOUR_MAX) begin
          day_nxt = wrap_inc(day_r, day_lim, cal_lo);
          if (day_r >= day_lim) begin
            mon_nxt = wrap_inc(mon_r, rtc_pkg::MON_MAX, cal_lo);
            if (mon_r >= rtc_pkg::MON_MAX) begin
              year_nxt = wrap_inc(year_r, rtc_pkg::YEAR_MAX, rtc_pkg::TIME_RST);
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_r  <= rtc_pkg::TIME_RST;
      min_r  <= rtc_pkg::TIME_RST;
      hour_r <= rtc_pkg::TIME_RST;
      day_r  <= rtc_pkg::TIME_RST;
      mon_r  <= rtc_pkg::TIME_RST;
      year_r <= rtc_pkg::TIME_RST;
    end else if (ce && tick) begin
      // staged set lands on the tick
      if (load_pend_r) begin
        sec_r  <= st_sec_r;
        min_r  <= st_min_r;
        hour_r <= st_hour_r;
        day_r  <= st_day_r;
        mon_r  <= st_mon_r;
        year_r <= st_year_r;
      end else begin
        sec_r  <= sec_nxt;
        min_r  <= min_nxt;
        hour_r <= hour_nxt;
        day_r  <= day_nxt;
        mon_r  <= mon_nxt;
        year_r <= year_nxt;
      end
    end
  end
endmodule

// *** rtl/rtc_host.sv ***
// Purpose: host end, turns Avalon-MM writes into 16-bit link frames
// Assumes: software orders the frames; one frame at a time
// Notes:   read answers come back on the frame after the request
`timescale 1ns/10ps
module rtc_host #(
  parameter int SCLK_HALF = rtc_pkg::SCLK_HALF_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // avalon slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // link
  rtc_spi_if.host          spi,
  // status
  output logic             busy
);
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_LOW  = 3'b001,
    HS_HIGH = 3'b010,
    HS_END  = 3'b011,
    HS_GAP  = 3'b100
  } rtc_hst_t;

  rtc_hst_t    state_r;
  logic [15:0] tx_sh_r, rx_sh_r, rx_r;
  logic [4:0]  bit_r;
  logic [15:0] half_r;
  logic        sclk_r, cs_n_r, mosi_r;
  logic [1:0]  miso_s;
  logic        ack_r, hold, start, half_done;

  assign busy            = (state_r != HS_IDLE);
  // tx write waits until the link is idle
  assign hold            = avs_write & (avs_address == rtc_pkg::AV_TX) & busy;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign start           = ack_r & avs_write & (avs_address == rtc_pkg::AV_TX);
  assign half_done       = (half_r == 16'(SCLK_HALF - 1));
  assign spi.sclk        = sclk_r;
  assign spi.cs_n        = cs_n_r;
  assign spi.mosi        = mosi_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r        <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else if (ce) begin
      ack_r <= (avs_read | avs_write) & ~ack_r & ~hold;
      if (avs_read && !ack_r) begin
        unique case (avs_address)
          rtc_pkg::AV_RX:   avs_readdata <= {16'h0000, rx_r};
          rtc_pkg::AV_STAT: avs_readdata <= {31'h0000_0000, busy};
          default:          avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // miso from the far end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      miso_s <= 2'b00;
    end else if (ce) begin
      miso_s <= {miso_s[0], spi.miso};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= HS_IDLE;
      tx_sh_r <= 16'h0000;
      rx_sh_r <= 16'h0000;
      rx_r    <= 16'h0000;
      bit_r   <= 5'h00;
      half_r  <= 16'h0000;
      sclk_r  <= 1'b1;
      cs_n_r  <= 1'b1;
      mosi_r  <= 1'b0;
    end else if (ce) begin
      half_r <= (state_r == HS_IDLE || half_done) ? 16'h0000 : half_r + 16'h0001;
      unique case (state_r)
        HS_IDLE: begin
          if (start) begin
            // order of frames is software's duty
            tx_sh_r <= {avs_writedata[14:0], 1'b0};
            mosi_r  <= avs_writedata[15];
            cs_n_r  <= 1'b0;
            sclk_r  <= 1'b0;
            bit_r   <= 5'h00;
            state_r <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (half_done) begin
            sclk_r  <= 1'b1;
            state_r <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (half_done) begin
            rx_sh_r <= {rx_sh_r[14:0], miso_s[1]};
            bit_r   <= bit_r + 5'h01;
            if (bit_r == 5'(rtc_pkg::FRAME_BITS - 1)) begin
              state_r <= HS_END;
            end else begin
              sclk_r  <= 1'b0;
              mosi_r  <= tx_sh_r[15];
              tx_sh_r <= {tx_sh_r[14:0], 1'b0};
              state_r <= HS_LOW;
            end
          end
        end
        HS_END: begin
          if (half_done) begin
            cs_n_r  <= 1'b1;
            rx_r    <= rx_sh_r;
            state_r <= HS_GAP;
          end
        end
        HS_GAP: begin
          if (half_done) begin
            state_r <= HS_IDLE;
          end
        end
        default: state_r <= HS_IDLE;
      endcase
    end
  end
endmodule
